// file: design/flash_read_param_config.sv
// Contract
// - Set-parameters opcode c0 loads the 8-bit read parameter register from its data byte.
// - Bits 6..4 are the dummy field; bits 1..0 the qpi wrap field.
// - In spi mode only the dummy field is written; wrap field kept.
// - In qpi mode both dummy and wrap fields are written.
// - Dummy field applies to spi eb/ec, qpi 0b/eb/0c, dtr ed, qpi dtr 0d/ed/0e.
// - In qpi mode wrap field sets boundary of 0c and 0e.
// - Qpi wrapped burst wraps at 8/16/32/64 byte section; no effect in spi.
// - Qpi eb, 0b, ed, 0d never wrap; address advances linearly.
// - Other spi fast reads use fixed dummy counts; eb, ec, ed follow field.
// - Spi wrap of eb and ed comes from spi wrap bits, not register.
// - Spi wrap bits and register unchanged across spi/qpi mode switches.
// - Register clears to zero at power up and every reset.
// - Spi eb/ec dummy: 000-010 give 6, then 8,10,12,14,16.
// - Qpi 0b/eb/0c dummy: 2,4,6,8,10,12,14,16 for codes 000..111.
// - Dtr reads dummy: 000-011 give 8, then 10,12,14,16.
// - Reset defaults: 6 spi, 2 qpi, 8 dtr dummy clocks.
// - Qpi wrap field: 00=8, 01=16, 10=32, 11=64 bytes.
`timescale 1ns/1ps
`default_nettype none
`include "flash_rp_defs.svh"

module flash_read_param_config
   import flash_rp_pkg::*;
#(
   parameter int ADDR_W = 32
)(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              soft_rst_i,
   input  wire logic              cs_n_i,
   input  wire logic              sclk_i,
   input  wire logic [3:0]        io_i,
   input  wire logic              qpi_mode_i,
   input  wire logic [2:0]        spi_wrap_bits_i,
   input  wire logic [7:0]        rd_op_i,
   input  wire logic [ADDR_W-1:0] rd_addr_i,
   output var  logic [7:0]        read_param_o,
   output var  logic              param_written_o,
   output var  read_cfg_t         cfg_o,
   output var  logic [ADDR_W-1:0] next_addr_o
);

   typedef enum logic [1:0] {
      st_wait_op,
      st_wait_data,
      st_skip
   } cmd_state_t;

   cmd_state_t  state;
   cmd_state_t  next_state;
   logic        frame;
   link_byte_t  lbyte;
   logic [7:0]  read_parameter_register;

   // ---------------------------------------------------------------
   // link byte capture
   // ---------------------------------------------------------------
   link_byte_shifter link_byte_shifter_i (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .cs_n_i  (cs_n_i),
      .sclk_i  (sclk_i),
      .io_i    (io_i),
      .quad_i  (qpi_mode_i),
      .frame_o (frame),
      .byte_o  (lbyte)
   );

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic read_class_t classify(input logic [7:0] op,
                                            input logic       qpi);
      read_class_t c;
      c = cls_fixed;
      if (qpi) begin
         case (op)
            `RP_OP_FAST_READ:   c = cls_qpi_cfg;
            `RP_OP_QUAD_IO:     c = cls_qpi_cfg;
            `RP_OP_BURST_WRAP:  c = cls_qpi_cfg;
            `RP_OP_DTR_FAST:    c = cls_dtr_cfg;
            `RP_OP_DTR_QUAD_IO: c = cls_dtr_cfg;
            `RP_OP_DTR_WRAP:    c = cls_dtr_cfg;
            default:            c = cls_fixed;
         endcase
      end else begin
         case (op)
            `RP_OP_QUAD_IO:     c = cls_spi_cfg;
            `RP_OP_QUAD_IO_4B:  c = cls_spi_cfg;
            `RP_OP_DTR_QUAD_IO: c = cls_dtr_cfg;
            default:            c = cls_fixed;
         endcase
      end
      return c;
   endfunction : classify

   // 2*code+2, the common ladder of all tables
   function automatic logic [4:0] dummy_ladder(input logic [2:0] code);
      return `RP_DUMMY_BASE + 5'({2'b00, code} * `RP_DUMMY_STEP);
   endfunction : dummy_ladder

   function automatic logic [4:0] dummy_for(input read_class_t c,
                                            input logic [2:0]  code);
      logic [4:0] d;
      d = dummy_ladder(code);
      case (c)
         cls_spi_cfg: begin
            if (d < `RP_SPI_MIN_DUMMY) begin
               d = `RP_SPI_MIN_DUMMY;
            end
         end
         cls_dtr_cfg: begin
            if (d < `RP_DTR_MIN_DUMMY) begin
               d = `RP_DTR_MIN_DUMMY;
            end
         end
         cls_qpi_cfg: begin
            d = dummy_ladder(code);
         end
         default: begin
            d = 5'h00;
         end
      endcase
      return d;
   endfunction : dummy_for

   function automatic logic [6:0] wrap_bytes(input logic [1:0] code);
      return `RP_WRAP_MIN_BYTES << code;
   endfunction : wrap_bytes

   // with wrap set, step inside an aligned section and carry never leaves it; without wrap, plain increment
   function automatic logic [ADDR_W-1:0] addr_step(
      input logic [ADDR_W-1:0] a,
      input logic              wrap,
      input logic [6:0]        len
   );
      logic [ADDR_W-1:0] mask;
      logic [ADDR_W-1:0] inc;
      mask = ADDR_W'(len) - ADDR_W'(1);
      inc = a + ADDR_W'(1);
      if (wrap) begin
         return (a & ~mask) | (inc & mask);
      end
      return inc;
   endfunction : addr_step

   // ---------------------------------------------------------------
   // command sequencing
   // ---------------------------------------------------------------
   wire        is_set_cmd = lbyte.valid & lbyte.first
                            & (lbyte.data == `RP_OP_SET_PARAMS);
   wire        param_byte = lbyte.valid & ~lbyte.first
                            & (state == st_wait_data);

   always_comb begin
      next_state = state;
      case (state)
         st_wait_op: begin
            if (lbyte.valid) begin
               next_state = is_set_cmd ? st_wait_data : st_skip;
            end
         end
         st_wait_data: begin
            if (lbyte.valid) begin
               next_state = st_skip;
            end
         end
         st_skip: begin
            next_state = st_skip;
         end
         default: begin
            next_state = st_wait_op;
         end
      endcase
      if (!frame) begin
         next_state = st_wait_op;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= st_wait_op;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // read parameter register
   // ---------------------------------------------------------------
   // spi write keeps the stored wrap field and the unused bits
   wire [7:0]  spi_merge = {read_parameter_register[7],
                            lbyte.data[`RP_DUMMY_MSB:`RP_DUMMY_LSB],
                            read_parameter_register[3:0]};
   wire [7:0]  next_param = qpi_mode_i ? lbyte.data
                                       : spi_merge;

   // mode switches never touch this register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_parameter_register <= `RP_RESET;
      end else if (soft_rst_i) begin
         read_parameter_register <= `RP_RESET;
      end else if (param_byte) begin
         read_parameter_register <= next_param;
      end
   end

   // ---------------------------------------------------------------
   // read configuration decode
   // ---------------------------------------------------------------
   wire [2:0]   dummy_code = read_parameter_register[`RP_DUMMY_MSB:`RP_DUMMY_LSB];
   wire [1:0]   wrap_code  = read_parameter_register[`RP_WRAP_MSB:`RP_WRAP_LSB];
   wire         rd_is_wrap = (rd_op_i == `RP_OP_BURST_WRAP)
                             | (rd_op_i == `RP_OP_DTR_WRAP);
   wire         spi_wrap_rd = (rd_op_i == `RP_OP_QUAD_IO)
                              | (rd_op_i == `RP_OP_QUAD_IO_4B)
                              | (rd_op_i == `RP_OP_DTR_QUAD_IO);
   wire         spi_wrap_on = ~spi_wrap_bits_i[`RP_SWRAP_DIS];
   wire [1:0]   spi_wrap_len = spi_wrap_bits_i[`RP_SWRAP_LEN_LSB +: 2];

   read_class_t rd_class;
   read_cfg_t   next_cfg;

   assign rd_class = classify(rd_op_i, qpi_mode_i);

   always_comb begin
      next_cfg = '0;
      next_cfg.configurable = (rd_class != cls_fixed);
      next_cfg.dummy_clocks = dummy_for(rd_class, dummy_code);
      if (qpi_mode_i) begin
         if (rd_is_wrap) begin
            next_cfg.wrap_en = 1'b1;
            next_cfg.wrap_bytes = wrap_bytes(wrap_code);
         end
      end else if (spi_wrap_rd && spi_wrap_on) begin
         next_cfg.wrap_en = 1'b1;
         next_cfg.wrap_bytes = wrap_bytes(spi_wrap_len);
      end
   end

   wire [ADDR_W-1:0] next_addr = addr_step(rd_addr_i, next_cfg.wrap_en,
                                           next_cfg.wrap_bytes);

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_param_o <= `RP_RESET;
         param_written_o <= 1'b0;
         cfg_o <= '0;
         next_addr_o <= '0;
      end else begin
         read_param_o <= read_parameter_register;
         param_written_o <= param_byte & ~soft_rst_i;
         cfg_o <= next_cfg;
         next_addr_o <= next_addr;
      end
   end

endmodule : flash_read_param_config
`default_nettype wire

// file: design/flash_rp_defs.svh
`ifndef FLASH_RP_DEFS_SVH
`define FLASH_RP_DEFS_SVH

// opcodes
`define RP_OP_SET_PARAMS  8'hc0
`define RP_OP_FAST_READ   8'h0b
`define RP_OP_BURST_WRAP  8'h0c
`define RP_OP_DTR_FAST    8'h0d
`define RP_OP_DTR_WRAP    8'h0e
`define RP_OP_QUAD_IO     8'heb
`define RP_OP_QUAD_IO_4B  8'hec
`define RP_OP_DTR_QUAD_IO 8'hed

// read parameter register layout
`define RP_RESET          8'h00
`define RP_DUMMY_MSB      6
`define RP_DUMMY_LSB      4
`define RP_WRAP_MSB       1
`define RP_WRAP_LSB       0

// spi wrap bits layout: [2:1] length, [0] disable
`define RP_SWRAP_DIS      0
`define RP_SWRAP_LEN_LSB  1

// dummy clock counts and minimum wrap length in bytes
`define RP_DUMMY_BASE     5'h02
`define RP_DUMMY_STEP     5'h02
`define RP_SPI_MIN_DUMMY  5'h06
`define RP_DTR_MIN_DUMMY  5'h08
`define RP_WRAP_MIN_BYTES 7'h08

// bits per link clock edge
`define RP_BITS_SPI       3'h1
`define RP_BITS_QPI       3'h4

`endif

// file: design/flash_rp_pkg.sv
package flash_rp_pkg;

   typedef enum logic [1:0] {
      cls_fixed,
      cls_spi_cfg,
      cls_qpi_cfg,
      cls_dtr_cfg
   } read_class_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       first;
   } link_byte_t;

   typedef struct packed {
      logic       configurable;
      logic [4:0] dummy_clocks;
      logic       wrap_en;
      logic [6:0] wrap_bytes;
   } read_cfg_t;

endpackage : flash_rp_pkg

// file: design/link_byte_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_rp_defs.svh"

module link_byte_shifter
   import flash_rp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       cs_n_i,
   input  wire logic       sclk_i,
   input  wire logic [3:0] io_i,
   input  wire logic       quad_i,
   output var  logic       frame_o,
   output var  link_byte_t byte_o
);

   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       sclk_prev;
   logic [7:0] shift;
   logic [2:0] nbits;
   logic       first;

   wire        cs_act    = ~sync2[5];
   wire        sclk_rise = sync2[4] & ~sclk_prev;
   wire [2:0]  step      = quad_i ? `RP_BITS_QPI : `RP_BITS_SPI;
   wire [7:0]  next_shift = quad_i ? {shift[3:0], sync2[3:0]}
                                   : {shift[6:0], sync2[0]};
   wire [2:0]  next_nbits = nbits + step;
   wire        byte_done = cs_act & sclk_rise & (next_nbits == 3'h0);

   // two-stage synchroniser for all link pins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1 <= 6'h3f;
         sync2 <= 6'h3f;
         sclk_prev <= 1'b1;
      end else begin
         sync1 <= {cs_n_i, sclk_i, io_i};
         sync2 <= sync1;
         sclk_prev <= sync2[4];
      end
   end

   // sample on rising link clock while selected
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift <= 8'h00;
         nbits <= 3'h0;
         first <= 1'b1;
         frame_o <= 1'b0;
         byte_o <= '0;
      end else begin
         frame_o <= cs_act;
         byte_o.valid <= byte_done;
         if (!cs_act) begin
            nbits <= 3'h0;
            first <= 1'b1;
         end else if (sclk_rise) begin
            shift <= next_shift;
            nbits <= next_nbits;
            if (byte_done) begin
               byte_o.data <= next_shift;
               byte_o.first <= first;
               first <= 1'b0;
            end
         end
      end
   end

endmodule : link_byte_shifter
`default_nettype wire

// file: test/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
   output var logic       cs_n_o,
   output var logic       sclk_o,
   output var logic [3:0] io_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      io_o = 4'h0;
   end
   // sclk idles low between frames, msb first
   task automatic send(input logic q, input logic [7:0] op, input logic [7:0] d);
      logic [15:0] w;
      w = {op, d};
      cs_n_o = 1'b0;
      for (int i = 0; i < (q ? 4 : 16); i++) begin
         io_o = q ? w[15:12] : {~w[15], ~w[15], ~w[15], w[15]};
         w = q ? w << 4 : w << 1;
         #400 sclk_o = 1'b1;
         #400 sclk_o = 1'b0;
      end
      #400 cs_n_o = 1'b1;
      io_o = ~io_o;
      #800;
   endtask : send
endmodule : flash_host_model
`default_nettype wire

// file: test/flash_read_param_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_read_param_config_tb
   import flash_rp_pkg::*;
();
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        soft_rst_i = 1'b0;
   logic        qpi_mode_i = 1'b0;
   logic [2:0]  spi_wrap_bits_i = 3'h1;
   logic [7:0]  rd_op_i = 8'h03;
   logic [31:0] rd_addr_i = 32'h0;
   logic        cs_n;
   logic        sclk;
   logic [3:0]  io;
   logic [7:0]  read_param_o;
   logic        param_written_o;
   read_cfg_t   cfg_o;
   logic [31:0] next_addr_o;
   int          err_count = 0;
   int          tests_run = 0;
   int          pulses = 0;
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (param_written_o === 1'b1) pulses <= pulses + 1;
   flash_read_param_config flash_read_param_config_i (.clk_i(clk_i), .rst_i(rst_i),
      .soft_rst_i(soft_rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io),
      .qpi_mode_i(qpi_mode_i), .spi_wrap_bits_i(spi_wrap_bits_i), .rd_op_i(rd_op_i),
      .rd_addr_i(rd_addr_i), .read_param_o(read_param_o), .param_written_o(param_written_o),
      .cfg_o(cfg_o), .next_addr_o(next_addr_o));
   flash_host_model flash_host_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));
   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : check
   task automatic wr(input logic q, input logic [7:0] op, input logic [7:0] d, input int n);
      int p0;
      p0 = pulses;
      @(negedge clk_i);
      qpi_mode_i = q;
      flash_host_model_i.send(q, op, d);
      repeat (10) @(negedge clk_i);
      check(pulses - p0 == n, "write pulse count");
   endtask : wr
   task automatic look(input logic q, input logic [7:0] op, input logic [31:0] a,
                       input logic [4:0] d, input logic wen, input logic [6:0] len);
      logic [31:0] m;
      m = 32'(len) - 1;
      @(negedge clk_i);
      qpi_mode_i = q;
      rd_op_i = op;
      rd_addr_i = a;
      repeat (2) @(negedge clk_i);
      check(cfg_o.dummy_clocks === d && cfg_o.configurable === (d != 5'h00), "dummy");
      check(cfg_o.wrap_en === wen && (!wen || cfg_o.wrap_bytes === len), "wrap");
      check(next_addr_o === (wen ? (a & ~m) | ((a + 1) & m) : a + 1), "next addr");
   endtask : look
   task automatic t_defaults;
      check(read_param_o === 8'h00, "reset value");
      look(1'b0, 8'heb, 32'h200, 5'h06, 1'b0, 7'h00);
      look(1'b1, 8'heb, 32'h200, 5'h02, 1'b0, 7'h00);
      look(1'b1, 8'h0d, 32'h200, 5'h08, 1'b0, 7'h00);
      look(1'b0, 8'h03, 32'h200, 5'h00, 1'b0, 7'h00);
   endtask : t_defaults
   task automatic t_writes;
      wr(1'b1, 8'hc0, 8'h01, 1);
      wr(1'b0, 8'hc0, 8'hfe, 1);
      check(read_param_o === 8'h71, "spi write kept wrap");
      look(1'b1, 8'h0c, 32'h10f, 5'h10, 1'b1, 7'h10);
      wr(1'b1, 8'hc0, 8'h8e, 1);
      check(read_param_o === 8'h8e, "qpi write all bits");
      look(1'b1, 8'h0e, 32'h21f, 5'h08, 1'b1, 7'h20);
      look(1'b1, 8'heb, 32'h21f, 5'h02, 1'b0, 7'h00);
   endtask : t_writes
   task automatic t_dummy;
      logic [2:0] c;
      logic [4:0] s;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         s = {1'b0, c, 1'b0} + 5'h02;
         wr(1'b1, 8'hc0, {1'b0, c, 4'h0}, 1);
         look(1'b0, 8'hec, 32'h0, c < 3'h3 ? 5'h06 : s, 1'b0, 7'h00);
         look(1'b1, 8'h0b, 32'h0, s, 1'b0, 7'h00);
         look(1'b0, 8'hed, 32'h0, c < 3'h4 ? 5'h08 : s, 1'b0, 7'h00);
         look(1'b1, 8'hed, 32'h0, c < 3'h4 ? 5'h08 : s, 1'b0, 7'h00);
      end
   endtask : t_dummy
   task automatic t_spi_wrap;
      for (int w = 0; w < 4; w++) begin
         spi_wrap_bits_i = {w[1:0], 1'b0};
         look(1'b0, 8'heb, 32'h33f, 5'h10, 1'b1, 7'h08 << w);
      end
      spi_wrap_bits_i = 3'h1;
   endtask : t_spi_wrap
   task automatic t_switch;
      int p0;
      p0 = pulses;
      repeat (3) begin
         @(negedge clk_i);
         qpi_mode_i = ~qpi_mode_i;
      end
      wr(1'b0, 8'h9f, 8'h00, 0);
      check(read_param_o === 8'h70 && pulses == p0, "register moved");
   endtask : t_switch
   task automatic t_soft;
      @(negedge clk_i);
      soft_rst_i = 1'b1;
      @(negedge clk_i);
      soft_rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      check(read_param_o === 8'h00, "soft clear");
      look(1'b1, 8'h0b, 32'h0, 5'h02, 1'b0, 7'h00);
   endtask : t_soft
   task automatic complete_run;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      t_defaults();
      t_writes();
      t_dummy();
      t_spi_wrap();
      t_switch();
      t_soft();
      complete_run();
   end
   initial begin
      #1_000_000;
      err_count++;
      complete_run();
   end
endmodule : flash_read_param_config_tb
`default_nettype wire

// file: test/flash_rp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_rp_checker
   import flash_rp_pkg::*;
#(
   parameter int ADDR_W = 32
)(
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              soft_rst_i,
   input wire logic              cs_n_i,
   input wire logic              sclk_i,
   input wire logic [3:0]        io_i,
   input wire logic              qpi_mode_i,
   input wire logic [2:0]        spi_wrap_bits_i,
   input wire logic [7:0]        rd_op_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   input wire logic [7:0]        read_param_o,
   input wire logic              param_written_o,
   input wire read_cfg_t         cfg_o,
   input wire logic [ADDR_W-1:0] next_addr_o
);
   logic              live;
   logic [7:0]        op_d;
   logic              q_d;
   logic [2:0]        w_d;
   logic [ADDR_W-1:0] a_d;
   // decode inputs seen one clock before the outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) live <= 1'b0;
      else live <= 1'b1;
   end
   always_ff @(posedge clk_i) begin
      op_d <= rd_op_i;
      q_d <= qpi_mode_i;
      w_d <= spi_wrap_bits_i;
      a_d <= rd_addr_i;
   end
   wire logic [2:0]        pd = read_param_o[6:4];
   wire logic [4:0]        dbl = {1'b0, pd, 1'b0} + 5'h02;
   wire logic              q_rd = q_d && (op_d inside {8'h0b, 8'heb, 8'h0c});
   wire logic              s_rd = !q_d && (op_d inside {8'heb, 8'hec});
   wire logic              d_rd = q_d ? (op_d inside {8'h0d, 8'hed, 8'h0e}) : op_d == 8'hed;
   wire logic              qw_rd = q_d && (op_d inside {8'h0c, 8'h0e});
   wire logic              ql_rd = q_d && (op_d inside {8'h0b, 8'heb, 8'h0d, 8'hed});
   wire logic              sw_rd = !q_d && (op_d inside {8'heb, 8'hec, 8'hed});
   wire logic [ADDR_W-1:0] msk = ADDR_W'(7'h08 << read_param_o[1:0]) - 1'b1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_pulse;
      param_written_o ##1 !param_written_o;
   endsequence
   property p_pulse; param_written_o |-> s_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse too long");
   // the pulse rises with the register, the register copy one clock later
   property p_hold;
      live && $changed(read_param_o) && !$past(soft_rst_i) && !$past(soft_rst_i, 2)
         && !$past(soft_rst_i, 3) |-> $past(param_written_o);
   endproperty
   a_hold: assert property (p_hold) else $error("register moved without write");
   property p_zero; $fell(rst_i) |-> read_param_o == 8'h00 && cfg_o == '0; endproperty
   a_zero: assert property (p_zero) else $error("register not clear after reset");
   property p_spi; live && s_rd |-> cfg_o.dummy_clocks == (pd < 3'h3 ? 5'h06 : dbl); endproperty
   a_spi: assert property (p_spi) else $error("spi dummy count wrong");
   property p_qpi; live && q_rd |-> cfg_o.configurable && cfg_o.dummy_clocks == dbl; endproperty
   a_qpi: assert property (p_qpi) else $error("qpi dummy count wrong");
   property p_dtr; live && d_rd |-> cfg_o.dummy_clocks == (pd < 3'h4 ? 5'h08 : dbl); endproperty
   a_dtr: assert property (p_dtr) else $error("dtr dummy count wrong");
   property p_qwrap;
      live && qw_rd |-> cfg_o.wrap_en && next_addr_o == ((a_d & ~msk) | ((a_d + 1'b1) & msk));
   endproperty
   a_qwrap: assert property (p_qwrap) else $error("qpi wrap address wrong");
   property p_lin; live && ql_rd |-> !cfg_o.wrap_en && next_addr_o == a_d + 1'b1; endproperty
   a_lin: assert property (p_lin) else $error("qpi linear read wrapped");
   property p_swrap; live && sw_rd |-> cfg_o.wrap_en == !w_d[0]; endproperty
   a_swrap: assert property (p_swrap) else $error("spi wrap enable wrong");
   property p_fixed;
      live && !(s_rd || q_rd || d_rd) |-> !cfg_o.configurable && cfg_o.dummy_clocks == 5'h00;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed read marked configurable");
endmodule : flash_rp_checker
bind flash_read_param_config flash_rp_checker #(.ADDR_W(ADDR_W)) flash_rp_checker_i (.*);
`default_nettype wire
